// ===== inc/scr_pkg.sv
// constants, strobe carrier and sequencer states for the serial character receiver
// assumes one 40 MHz clock and an external baud clock at eight times the bit rate
package scr_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned MATCH_SETUP_NS = 50;
   localparam logic [1:0] MATCH_SETUP_CYC =
      2'((MATCH_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [2:0] TICK_LAST = 3'h7;
   localparam logic [2:0] HALF_LAST = 3'h3;
   localparam logic [2:0] LAST_BIT_LONG = 3'h7;
   localparam logic [2:0] LAST_BIT_SHORT = 3'h4;
   localparam logic [7:0] DATA_IDLE_N = 8'hFF;
   localparam logic [7:0] WORD_RST = 8'h00;
   localparam int unsigned CHAR_W = 8;
   localparam int unsigned FIFO_DEPTH = 32;

   typedef struct packed {
      logic flag_query;
      logic read_xfer;
      logic clr_sel;
      logic clr_unsel;
      logic io_init;
   } scr_strobe_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_START = 2'b01,
      ST_DATA = 2'b10,
      ST_TAIL = 2'b11
   } scr_state_t;
endpackage : scr_pkg

// ===== logic/scr_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes the pins may change at any time relative to ref_clk_in
`timescale 1ns/10ps
module scr_sync #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= d_in;
         sync_q <= meta_q;
      end
   end

   assign q_out = sync_q;
endmodule : scr_sync

// ===== logic/scr_fifo.sv
// character fifo with registered read data, valid/ready on both sides
// assumes push and pop come from logic on the same clock
`timescale 1ns/10ps
module scr_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = 32
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic out_valid_q;
   logic [W-1:0] out_data_q;

   wire empty = (wr_q == rd_q);
   wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire push = in_valid_in && !full;
   wire pop = !empty && (!out_valid_q || out_ready_in);

   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wr_q <= '0;
         rd_q <= '0;
         out_valid_q <= 1'b0;
         out_data_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
            out_data_q <= mem_q[rd_q[AW-1:0]];
            out_valid_q <= 1'b1;
         end else if (out_ready_in) begin
            out_valid_q <= 1'b0;
         end
      end
   end

   assign in_ready_out = !full;
   assign out_valid_out = out_valid_q;
   assign out_data_out = out_data_q;
endmodule : scr_fifo

// ===== logic/scr_receiver.sv
// serial character receiver: baud-clock sampling, ready flag, gated host strobes,
// active-low parallel outputs, tape reader control and a character fifo tap
// assumes every pin but char_ready_in is asynchronous to ref_clk_in; baud clock is eight times bit rate
`timescale 1ns/10ps
module scr_receiver #(
   parameter int unsigned NMATCH = 6,
   parameter int unsigned FIFO_DEPTH = scr_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic baud_clk_in,
   input wire logic serial_in,
   input wire logic rx_enable_in,
   input wire logic char8_sel_in,
   input wire logic [NMATCH-1:0] dev_match_in,
   input wire logic sel_qual_en_in,
   input wire scr_pkg::scr_strobe_t strobes_in,
   input wire logic reader_set_n_in,
   input wire logic char_ready_in,
   output logic [7:0] data_n_out,
   output logic ready_flag_n_out,
   output logic strobed_flag_n_out,
   output logic receiving_n_out,
   output logic reader_state_out,
   output logic reader_drive_out,
   output logic any_clear_out,
   output logic selected_clear_out,
   output logic char_valid_out,
   output logic [7:0] char_data_out,
   output logic char_room_out
);
   localparam int unsigned SW = 5 + NMATCH + 5;

   // synchronised pins
   logic [SW-1:0] sync_s;
   logic reader_set_n_s;
   scr_sync #(.W(SW), .RST_VAL('0)) u_sync_pins (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .d_in({baud_clk_in, serial_in, rx_enable_in, char8_sel_in, sel_qual_en_in,
             dev_match_in, strobes_in}),
      .q_out(sync_s)
   );
   scr_sync #(.W(1), .RST_VAL(1'b1)) u_sync_reader (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .d_in(reader_set_n_in),
      .q_out(reader_set_n_s)
   );

   scr_pkg::scr_strobe_t stb_s;
   wire baud_s = sync_s[SW-1];
   wire serial_s = sync_s[SW-2];
   wire rx_en_s = sync_s[SW-3];
   wire char8_s = sync_s[SW-4];
   wire sel_en_s = sync_s[SW-5];
   wire [NMATCH-1:0] match_s = sync_s[NMATCH+4:5];
   assign stb_s = sync_s[4:0];

   // state
   scr_pkg::scr_state_t state_q;
   scr_pkg::scr_state_t state_d;
   logic [2:0] tick_cnt_q;
   logic [2:0] tick_cnt_d;
   logic [2:0] bit_cnt_q;
   logic [2:0] bit_cnt_d;
   logic [7:0] shift_q;
   logic [7:0] word_q;
   logic [7:0] data_n_q;
   logic flag_q;
   logic reader_q;
   logic receiving_n_q;
   logic baud_prev_q;
   logic [1:0] match_cnt_q;

   // decode
   wire tick = baud_s && !baud_prev_q;
   wire rx_bit = !serial_s;
   wire match_raw = (&match_s) || !sel_en_s;
   wire match_ok = match_raw && (match_cnt_q >= scr_pkg::MATCH_SETUP_CYC);
   wire query_ok = stb_s.flag_query && match_ok;
   wire read_ok = stb_s.read_xfer && match_ok;
   wire sel_clr_ok = stb_s.clr_sel && match_ok;
   wire clear_any = stb_s.io_init || stb_s.clr_unsel || sel_clr_ok;
   wire fifo_room;
   wire start_edge = (state_q == scr_pkg::ST_IDLE) && rx_en_s && !rx_bit
                     && fifo_room && !stb_s.io_init;
   wire [2:0] last_bit = char8_s ? scr_pkg::LAST_BIT_LONG : scr_pkg::LAST_BIT_SHORT;
   wire sample = (state_q == scr_pkg::ST_DATA) && tick
                 && (tick_cnt_q == scr_pkg::TICK_LAST);
   wire sample_last = sample && (bit_cnt_q == last_bit);
   wire [7:0] shift_next = {rx_bit, shift_q[7:1]};
   wire [7:0] word_next = char8_s ? shift_next : {3'h0, shift_next[7:3]};

   // sequencer
   always_comb begin
      state_d = state_q;
      tick_cnt_d = tick_cnt_q;
      bit_cnt_d = bit_cnt_q;
      unique case (state_q)
         scr_pkg::ST_IDLE: begin
            if (start_edge) begin
               state_d = scr_pkg::ST_START;
               tick_cnt_d = 3'h0;
            end
         end
         scr_pkg::ST_START: begin
            if (tick) begin
               tick_cnt_d = tick_cnt_q + 3'h1;
               if (tick_cnt_q == scr_pkg::HALF_LAST) begin
                  tick_cnt_d = 3'h0;
                  bit_cnt_d = 3'h0;
                  state_d = rx_bit ? scr_pkg::ST_IDLE : scr_pkg::ST_DATA;
               end
            end
         end
         scr_pkg::ST_DATA: begin
            if (tick) begin
               tick_cnt_d = tick_cnt_q + 3'h1;
            end
            if (sample) begin
               bit_cnt_d = bit_cnt_q + 3'h1;
               if (sample_last) begin
                  state_d = scr_pkg::ST_TAIL;
               end
            end
         end
         scr_pkg::ST_TAIL: begin
            if (tick) begin
               tick_cnt_d = tick_cnt_q + 3'h1;
               if (tick_cnt_q == scr_pkg::HALF_LAST) begin
                  state_d = scr_pkg::ST_IDLE;
               end
            end
         end
      endcase
      if (stb_s.io_init) begin
         state_d = scr_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= scr_pkg::ST_IDLE;
         tick_cnt_q <= 3'h0;
         bit_cnt_q <= 3'h0;
         baud_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tick_cnt_q <= tick_cnt_d;
         bit_cnt_q <= bit_cnt_d;
         baud_prev_q <= baud_s;
      end
   end

   // shift register and held word
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         shift_q <= scr_pkg::WORD_RST;
         word_q <= scr_pkg::WORD_RST;
      end else begin
         if (sample) begin
            shift_q <= shift_next;
         end
         if (sample_last) begin
            word_q <= word_next;
         end
      end
   end

   // ready flag: a held clear keeps it from setting
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flag_q <= 1'b0;
      end else if (clear_any) begin
         flag_q <= 1'b0;
      end else if (sample_last) begin
         flag_q <= 1'b1;
      end
   end

   // outputs from flops
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         data_n_q <= scr_pkg::DATA_IDLE_N;
         receiving_n_q <= 1'b1;
         reader_q <= 1'b0;
         match_cnt_q <= 2'h0;
      end else begin
         data_n_q <= read_ok ? ~word_q : scr_pkg::DATA_IDLE_N;
         receiving_n_q <= (state_d == scr_pkg::ST_IDLE);
         if (!reader_set_n_s) begin
            reader_q <= 1'b1;
         end else if (start_edge) begin
            reader_q <= 1'b0;
         end
         if (!match_raw) begin
            match_cnt_q <= 2'h0;
         end else if (match_cnt_q < scr_pkg::MATCH_SETUP_CYC) begin
            match_cnt_q <= match_cnt_q + 2'h1;
         end
      end
   end

   // character tap; a full fifo holds off new starts
   scr_fifo #(.W(scr_pkg::CHAR_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(sample_last),
      .in_data_in(word_next),
      .in_ready_out(fifo_room),
      .out_valid_out(char_valid_out),
      .out_data_out(char_data_out),
      .out_ready_in(char_ready_in)
   );

   assign data_n_out = data_n_q;
   assign ready_flag_n_out = !flag_q;
   assign strobed_flag_n_out = !(flag_q && query_ok);
   assign receiving_n_out = receiving_n_q;
   assign reader_state_out = reader_q;
   assign reader_drive_out = reader_q;
   assign any_clear_out = !(stb_s.clr_sel || stb_s.clr_unsel || stb_s.io_init);
   assign selected_clear_out = !sel_clr_ok;
   assign char_room_out = fifo_room;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);

   a_init_clears: assert property (stb_s.io_init |=> !flag_q && state_q == scr_pkg::ST_IDLE)
      else $error("bus init did not clear flag and sequencer");
   a_unsel_clear: assert property (stb_s.clr_unsel |=> !flag_q)
      else $error("unselected clear left flag set");
   a_sel_clear_hold: assert property (sel_clr_ok [*3] |=> !flag_q)
      else $error("flag set while selected clear held");
   a_flag_at_last: assert property (sample_last && !clear_any
      |=> flag_q && word_q == $past(word_next))
      else $error("flag or word missing at last data bit");
   a_read_copy: assert property (read_ok |=> data_n_q == ~word_q)
      else $error("read strobe did not present word");
   a_idle_high: assert property (!read_ok |=> data_n_q == scr_pkg::DATA_IDLE_N)
      else $error("bit outputs not idle without read");
   a_start_reject: assert property (state_q == scr_pkg::ST_START && tick && rx_bit
      && tick_cnt_q == scr_pkg::HALF_LAST && !stb_s.io_init |=> state_q == scr_pkg::ST_IDLE)
      else $error("short start bit was accepted");
   a_tail_release: assert property ($rose(flag_q) |-> state_q == scr_pkg::ST_TAIL
      && !receiving_n_q)
      else $error("receiving indicator wrong at flag set");
   a_short_upper: assert property (sample_last && !char8_s |-> word_next[7:5] == 3'h0)
      else $error("5-bit word has upper bits set");
   a_reader_clear: assert property (start_edge && reader_set_n_s |=> !reader_q)
      else $error("reader flop not cleared at start bit");
   a_gated_flag: assert property (flag_q && query_ok |-> !strobed_flag_n_out ##1 1)
      else $error("gated flag did not pulse low");
   a_unmatched_read: assert property (!match_raw |=> data_n_q == scr_pkg::DATA_IDLE_N)
      else $error("read acted without device match");

   // sequencer and receiving indicator
   a_start_enter: assert property (start_edge
      |=> state_q == scr_pkg::ST_START && !receiving_n_q)
      else $error("start edge did not enter start state");

   a_recv_level: assert property (receiving_n_q
      == (state_q == scr_pkg::ST_IDLE))
      else $error("receiving indicator disagrees with sequencer");

   a_enable_block: assert property (!rx_en_s && state_q == scr_pkg::ST_IDLE
      |=> state_q == scr_pkg::ST_IDLE)
      else $error("reception began while disabled");

   a_bit_range: assert property (state_q == scr_pkg::ST_DATA
      |-> bit_cnt_q <= last_bit)
      else $error("bit count ran past last data bit");

   a_data_exit: assert property (sample_last && !stb_s.io_init
      |=> state_q == scr_pkg::ST_TAIL)
      else $error("sequencer did not leave data state");

   a_init_recv: assert property (stb_s.io_init
      |=> receiving_n_q)
      else $error("bus init left receiving indicator low");

   // ready flag and held word
   a_flag_hold: assert property (flag_q && !clear_any
      |=> flag_q)
      else $error("flag dropped without a clear");

   a_clear_wins: assert property (clear_any && sample_last
      |=> !flag_q)
      else $error("flag set while a clear was present");

   a_word_hold: assert property (!sample_last
      |=> $stable(word_q))
      else $error("held word changed between characters");

   // host strobes
   a_query_unmatched: assert property (!match_ok
      |-> strobed_flag_n_out)
      else $error("query acted without device match");

   a_read_matched: assert property (read_ok
      |-> match_raw)
      else $error("read taken without device match");

   // reader flop and fifo
   a_reader_set: assert property (!reader_set_n_s
      |=> reader_q)
      else $error("reader flop not set by set input");

   a_push_room: assert property (sample_last
      |-> fifo_room)
      else $error("character pushed into a full fifo");
endmodule : scr_receiver

// ===== verif/scr_line_model.sv
// far side of the receiver: free running baud clock source and a serial line sender
// assumes the caller invokes send at a falling edge of ref_clk_in
`timescale 1ns/10ps
module scr_line_model #(
   parameter int BIT_CLKS = 64
) (
   input wire logic ref_clk_in,
   output logic baud_clk_out,
   output logic serial_out
);
   logic [2:0] ph_q = 3'h0;
   initial serial_out = 1'b0;
   // eight baud periods per bit, each high for four system clocks
   always @(negedge ref_clk_in) begin
      ph_q <= ph_q + 3'h1;
   end
   assign baud_clk_out = ph_q[2];
   // start_clks below one bit makes a runt start and ends the frame there
   task automatic send(input logic [7:0] w, input int nbits, input int stop_half,
                       input int start_clks);
      serial_out = 1'b1;
      repeat (start_clks) @(negedge ref_clk_in);
      if (start_clks < BIT_CLKS) begin
         serial_out = 1'b0;
         return;
      end
      for (int i = 0; i < nbits; i++) begin
         serial_out = ~w[i];
         repeat (BIT_CLKS) @(negedge ref_clk_in);
      end
      serial_out = 1'b0;
      repeat (stop_half * BIT_CLKS / 2) @(negedge ref_clk_in);
   endtask : send
endmodule : scr_line_model

// ===== verif/test_scr_receiver.sv
// self-checking bench for the serial character receiver
// assumes a 40 MHz clock, eight baud clocks per bit and 64 system clocks per bit
`timescale 1ns/10ps
module test_scr_receiver;
   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic rx_enable_in = 1'b1;
   logic char8_sel_in = 1'b1;
   logic sel_qual_en_in = 1'b1;
   logic reader_set_n_in = 1'b1;
   logic char_ready_in = 1'b0;
   logic [5:0] dev_match_in = 6'h3F;
   logic [4:0] strb = 5'h00;
   logic baud_clk, serial;
   logic [7:0] data_n_out, char_data_out;
   logic ready_flag_n_out, strobed_flag_n_out, receiving_n_out, reader_state_out;
   logic reader_drive_out, any_clear_out, selected_clear_out, char_valid_out, char_room_out;
   int err_total = 0;
   int num_checks = 0;
   logic [7:0] q[$];

   scr_line_model line (.ref_clk_in(ref_clk_in), .baud_clk_out(baud_clk), .serial_out(serial));
   scr_receiver dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .baud_clk_in(baud_clk),
      .serial_in(serial), .rx_enable_in(rx_enable_in), .char8_sel_in(char8_sel_in),
      .dev_match_in(dev_match_in), .sel_qual_en_in(sel_qual_en_in),
      .strobes_in(scr_pkg::scr_strobe_t'(strb)), .reader_set_n_in(reader_set_n_in),
      .char_ready_in(char_ready_in), .data_n_out(data_n_out),
      .ready_flag_n_out(ready_flag_n_out), .strobed_flag_n_out(strobed_flag_n_out),
      .receiving_n_out(receiving_n_out), .reader_state_out(reader_state_out),
      .reader_drive_out(reader_drive_out), .any_clear_out(any_clear_out),
      .selected_clear_out(selected_clear_out), .char_valid_out(char_valid_out),
      .char_data_out(char_data_out), .char_room_out(char_room_out));

   initial begin
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask : cyc

   // match is held for several cycles before each strobe raised in rx_one, except the unselected clear, raised one cycle after match drops
   task automatic strobe(input int idx, input logic v);
      cyc(1);
      strb[idx] = v;
      cyc(4);
   endtask : strobe

   function automatic logic [7:0] exp_w(input logic [7:0] w, input logic c8);
      return c8 ? w : {3'h0, w[4:0]};
   endfunction : exp_w

   task automatic pop_chk(input logic [7:0] exp);
      chk("fifo valid", 8'h01, char_valid_out);
      chk("fifo data", exp, char_data_out);
      char_ready_in = 1'b1;
      cyc(1);
      char_ready_in = 1'b0;
      cyc(2);
   endtask : pop_chk

   task automatic rx_one(input logic [7:0] w, input logic c8, input int stop_half, input int how);
      int n;
      int m;
      char8_sel_in = c8;
      cyc(4);
      fork
         line.send(w, c8 ? 8 : 5, stop_half, 64);
         begin
            n = 0;
            while (ready_flag_n_out !== 1'b0 && n < 2000) begin
               cyc(1);
               n++;
            end
            chk("receiving_n at flag", 8'h00, receiving_n_out);
            m = 0;
            while (receiving_n_out !== 1'b1 && m < 100) begin
               cyc(1);
               m++;
            end
            chk("flag to idle gap", 8'h01, 8'(m >= 29 && m <= 35));
         end
      join
      chk("ready_flag_n", 8'h00, ready_flag_n_out);
      chk("data idle", 8'hFF, data_n_out);
      strobe(3, 1'b1);
      chk("data_n", ~exp_w(w, c8), data_n_out);
      strobe(3, 1'b0);
      chk("data idle", 8'hFF, data_n_out);
      strobe(4, 1'b1);
      chk("strobed flag", 8'h00, strobed_flag_n_out);
      strobe(4, 1'b0);
      chk("strobed idle", 8'h01, strobed_flag_n_out);
      pop_chk(exp_w(w, c8));
      case (how)
         0: begin
            strobe(2, 1'b1);
            chk("selected clear", 8'h00, selected_clear_out);
            chk("any clear", 8'h00, any_clear_out);
            strobe(2, 1'b0);
         end
         1: begin
            dev_match_in = 6'h15;
            strobe(1, 1'b1);
            chk("any clear", 8'h00, any_clear_out);
            strobe(1, 1'b0);
            dev_match_in = 6'h3F;
         end
         default: begin
            strobe(0, 1'b1);
            chk("any clear", 8'h00, any_clear_out);
            strobe(0, 1'b0);
         end
      endcase
      chk("flag cleared", 8'h01, ready_flag_n_out);
      chk("any clear idle", 8'h01, any_clear_out);
   endtask : rx_one

   initial begin
      repeat (100000) @(posedge ref_clk_in);
      err_total++;
      finish_test();
   end

   initial begin
      logic [7:0] w;
      int n;
      void'($urandom(98));
      repeat (4) @(posedge ref_clk_in);
      chk("reset data", 8'hFF, data_n_out);
      chk("reset flag", 8'h01, ready_flag_n_out);
      chk("reset room", 8'h01, char_room_out);
      cyc(1);
      nrst_in = 1'b1;
      cyc(4);
      reader_set_n_in = 1'b0;
      cyc(3);
      reader_set_n_in = 1'b1;
      cyc(3);
      chk("reader set", 8'h01, reader_state_out);
      chk("reader drive", 8'h01, reader_drive_out);
      for (int i = 0; i < 6; i++) begin
         w = (i == 1) ? 8'hFF : 8'($urandom);
         rx_one(w, ~i[0], 2 + i % 3, i % 3);
         chk("reader off", 8'h00, reader_state_out);
         chk("reader drive off", 8'h00, reader_drive_out);
      end
      char8_sel_in = 1'b1;
      w = 8'($urandom);
      line.send(w, 8, 2, 64);
      dev_match_in = 6'h2F;
      cyc(4);
      strobe(4, 1'b1);
      chk("unmatched query", 8'h01, strobed_flag_n_out);
      strobe(4, 1'b0);
      strobe(3, 1'b1);
      chk("unmatched read", 8'hFF, data_n_out);
      strobe(3, 1'b0);
      strobe(2, 1'b1);
      chk("unmatched clear", 8'h00, ready_flag_n_out);
      strobe(2, 1'b0);
      sel_qual_en_in = 1'b0;
      cyc(4);
      strobe(3, 1'b1);
      chk("bypass read", ~w, data_n_out);
      strobe(3, 1'b0);
      sel_qual_en_in = 1'b1;
      dev_match_in = 6'h3F;
      cyc(4);
      pop_chk(w);
      strobe(2, 1'b1);
      w = 8'($urandom);
      line.send(w, 8, 2, 64);
      chk("flag held clear", 8'h01, ready_flag_n_out);
      strobe(2, 1'b0);
      chk("flag stays clear", 8'h01, ready_flag_n_out);
      pop_chk(w);
      line.send(8'h00, 8, 2, 16);
      cyc(80);
      chk("runt flag", 8'h01, ready_flag_n_out);
      chk("runt idle", 8'h01, receiving_n_out);
      chk("runt fifo", 8'h00, char_valid_out);
      rx_enable_in = 1'b0;
      cyc(4);
      line.send(8'($urandom), 8, 4, 64);
      chk("disabled flag", 8'h01, ready_flag_n_out);
      chk("disabled fifo", 8'h00, char_valid_out);
      rx_enable_in = 1'b1;
      cyc(4);
      n = 0;
      while (char_room_out === 1'b1 && n < 40) begin
         w = 8'($urandom);
         q.push_back(w);
         line.send(w, 8, 2, 64);
         n++;
         cyc(4);
      end
      chk("fill count", 8'h01, 8'(n == scr_pkg::FIFO_DEPTH + 1));
      while (q.size() > 0) begin
         cyc($urandom % 3);
         pop_chk(q.pop_front());
      end
      chk("drained room", 8'h01, char_room_out);
      chk("drained valid", 8'h00, char_valid_out);
      finish_test();
   end
endmodule : test_scr_receiver
